// ### bus_transfer_pkg.sv
// Package for the bus transfer interlock: role and scheme codes,
// register offsets and field positions, timebase and delay defaults.
// Assumes a 20 MHz reference clock.
package bus_transfer_pkg;

	// Breaker role selection
	typedef enum logic [1:0] {
		ROLE_DISABLED,
		ROLE_INCOMER1,
		ROLE_INCOMER2,
		ROLE_BUS_TIE
	} role_t;

	// Sequencer states for an incomer transfer
	typedef enum logic [1:0] {
		XFER_IDLE,
		XFER_TRIP,
		XFER_DONE
	} xfer_state_t;

	// Clock and timebase
	localparam int unsigned CLK_HZ = 20000000;
	localparam int unsigned TICK_US = 1000;
	localparam int unsigned TICK_CYCLES = (CLK_HZ / 1000000) * TICK_US;
	localparam logic [15:0] TICK_LAST = 16'(TICK_CYCLES - 1);

	// Register offsets
	localparam logic [3:0] REG_CTRL = 4'h0;
	localparam logic [3:0] REG_LOCAL_DLY = 4'h1;
	localparam logic [3:0] REG_OTHER_DLY = 4'h2;
	localparam logic [3:0] REG_PAR_DLY = 4'h3;
	localparam logic [3:0] REG_STATUS = 4'h4;

	// Control field positions
	localparam int CTRL_ROLE_LO = 0;
	localparam int CTRL_SCHEME = 2;
	localparam int CTRL_DBL_INH = 3;
	localparam int CTRL_RDY_EN = 4;

	// Reset values
	localparam logic [1:0] ROLE_RST = 2'h0;
	localparam logic SCHEME_RST = 1'b0;
	localparam logic [15:0] DLY_RST = 16'h0064;

endpackage

// ### bus_transfer_interlock.sv
// Bus transfer interlock for one relay of a three-breaker auto transfer.
// Assumes contact inputs and protection element results arrive
// asynchronously and are synchronised here; register port is on i_ref_clk.
//
// Operation
// RULE1: Role setting: disabled, incomer one/two, tie
// RULE2: Scheme select, scheme one after reset
// RULE3: All three relays use same scheme
// RULE4: Local recovery delay after overcurrent resets
// RULE5: Double-loss return inhibit interval
// RULE6: Double loss: undervoltage trip unless inhibited
// RULE7: Never transfer-close tie on double loss
// RULE8: Parallel-trip delay expiry trips selected breaker
// RULE9: Incomer parallel-trip start conditions
// RULE10: Tie parallel-trip start conditions
// RULE11: Incomer transfer-ready conditions
// RULE12: Tie transfer-ready conditions
// RULE13: Ready enable drives auxiliary output three
// RULE14: Outputs four to seven only for transfer
// RULE15: Instantaneous overcurrent blocks incomer transfer
// RULE16: Fast undervoltage signals opposite incomer
// RULE17: Timed undervoltage initiates transfer
// RULE18: Undervoltage pickups must differ
// RULE19: Tie blocks sync-close during transfer
// RULE20: Incomer dead permission live-line-dead-bus; no dead permission logic here
// RULE21: Tie dead permission dead-line-or-dead-bus; no dead permission logic here
// RULE22: Incomer trips, requests close, holds till open
// RULE23: Tie latches close request till closed/blocked
// RULE24: Delays count ticks, restart when dropped
`timescale 1ns/1ps
`default_nettype none

module bus_transfer_interlock
	import bus_transfer_pkg::*;
(
	input wire logic i_ref_clk,
	input wire logic i_reset_n,
	input wire logic [3:0] i_addr,
	input wire logic [15:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [15:0] o_rdata,
	input wire logic i_own_connected,
	input wire logic i_own_closed,
	input wire logic i_other_closed,
	input wire logic i_tie_connected,
	input wire logic i_tie_closed,
	input wire logic i_parallel_trip_selection_input,
	input wire logic i_block_transfer,
	input wire logic i_lockout,
	input wire logic i_source_trip,
	input wire logic i_other_uv,
	input wire logic i_close_req,
	input wire logic i_inst_phase_overcurrent,
	input wire logic i_inst_neutral_overcurrent,
	input wire logic i_fast_uv,
	input wire logic i_timed_uv,
	input wire logic i_other_source_lost,
	output logic o_aux3_ready,
	output logic o_aux4_uv_other,
	output logic o_aux5_close_req,
	output logic o_aux6_tie_close,
	output logic o_aux7_sync_block,
	output logic o_trip
);

	localparam int NSYNC = 16;

	// Raw asynchronous inputs grouped for one synchroniser loop
	logic [NSYNC-1:0] raw_in;
	logic [NSYNC-1:0] sync1_q;
	logic [NSYNC-1:0] sync2_q;

	assign raw_in = {i_own_connected, i_own_closed, i_other_closed, i_tie_connected,
		i_tie_closed, i_parallel_trip_selection_input, i_block_transfer, i_lockout,
		i_source_trip, i_other_uv, i_close_req, i_inst_phase_overcurrent,
		i_inst_neutral_overcurrent, i_fast_uv, i_timed_uv, i_other_source_lost};

	// Two-flop synchroniser per input bit; stage one feeds stage two only
	genvar gi;
	generate
		for (gi = 0; gi < NSYNC; gi++) begin : g_sync
			always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
				if (!i_reset_n) begin
					sync1_q[gi] <= 1'b0;
					sync2_q[gi] <= 1'b0;
				end else begin
					sync1_q[gi] <= raw_in[gi];
					sync2_q[gi] <= sync1_q[gi];
				end
			end
		end
	endgenerate

	// Synchronised names
	logic own_conn, own_cl, oth_cl, tie_conn, tie_cl, sel_trip, blk;
	logic lockout, src_trip, oth_uv, close_in, oc_p, oc_n, fast_uv, timed_uv, oth_lost;
	assign {own_conn, own_cl, oth_cl, tie_conn, tie_cl, sel_trip, blk, lockout, src_trip,
		oth_uv, close_in, oc_p, oc_n, fast_uv, timed_uv, oth_lost} = sync2_q;

	// Settings
	role_t role_q;
	logic scheme_q; // 0 = scheme one
	logic dbl_inh_q; // Double-loss trip inhibit
	logic rdy_en_q; // Ready indication enable
	logic [15:0] local_dly_q;
	logic [15:0] other_dly_q;
	logic [15:0] par_dly_q;

	// Register writes
	always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			role_q <= role_t'(ROLE_RST);
			scheme_q <= SCHEME_RST; // [RULE2]
			dbl_inh_q <= 1'b0;
			rdy_en_q <= 1'b0;
			local_dly_q <= DLY_RST;
			other_dly_q <= DLY_RST;
			par_dly_q <= DLY_RST;
		end else if (i_wr) begin
			case (i_addr)
				REG_CTRL: begin
					role_q <= role_t'(i_wdata[CTRL_ROLE_LO +: 2]); // [RULE1]
					scheme_q <= i_wdata[CTRL_SCHEME];
					dbl_inh_q <= i_wdata[CTRL_DBL_INH];
					rdy_en_q <= i_wdata[CTRL_RDY_EN];
				end
				REG_LOCAL_DLY: local_dly_q <= i_wdata;
				REG_OTHER_DLY: other_dly_q <= i_wdata;
				REG_PAR_DLY: par_dly_q <= i_wdata;
				default: ;
			endcase
		end
	end

	// Fixed timebase: one-cycle tick every TICK_CYCLES
	logic [15:0] tick_cnt_q;
	logic tick;
	assign tick = (tick_cnt_q == TICK_LAST);
	always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
		if (!i_reset_n) tick_cnt_q <= 16'h0000;
		else if (tick) tick_cnt_q <= 16'h0000;
		else tick_cnt_q <= tick_cnt_q + 16'h0001;
	end

	// Role decode
	logic is_inc, is_tie;
	assign is_inc = (role_q == ROLE_INCOMER1) || (role_q == ROLE_INCOMER2); // [RULE1]
	assign is_tie = (role_q == ROLE_BUS_TIE);

	// Overcurrent on load side, and its recovery window
	logic oc_any;
	logic oc_prev_q;
	logic rec_run_q;
	logic [15:0] rec_cnt_q;
	assign oc_any = oc_p | oc_n;

	// Recovery interval: armed on overcurrent reset, restarts on fast undervoltage
	always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			oc_prev_q <= 1'b0;
			rec_run_q <= 1'b0;
			rec_cnt_q <= 16'h0000;
		end else begin
			oc_prev_q <= oc_any;
			if (oc_any) begin
				rec_run_q <= 1'b0;
				rec_cnt_q <= 16'h0000;
			end else if (oc_prev_q) begin
				rec_run_q <= 1'b1; // [RULE4]
				rec_cnt_q <= 16'h0000;
			end else if (rec_run_q && fast_uv) begin
				rec_cnt_q <= 16'h0000; // Voltage must stay up the whole interval [RULE24]
			end else if (rec_run_q && tick) begin
				if (rec_cnt_q >= local_dly_q) rec_run_q <= 1'b0;
				else rec_cnt_q <= rec_cnt_q + 16'h0001;
			end
		end
	end

	// Double loss tracking and return inhibit
	logic dbl_loss;
	logic dbl_seen_q;
	logic ret_run_q;
	logic [15:0] ret_cnt_q;
	assign dbl_loss = timed_uv & oth_lost;

	// Inhibit starts when the first source returns after a double loss
	always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			dbl_seen_q <= 1'b0;
			ret_run_q <= 1'b0;
			ret_cnt_q <= 16'h0000;
		end else begin
			if (dbl_loss) begin
				dbl_seen_q <= 1'b1;
				ret_run_q <= 1'b0;
				ret_cnt_q <= 16'h0000;
			end else if (dbl_seen_q) begin
				dbl_seen_q <= 1'b0;
				ret_run_q <= 1'b1; // [RULE5]
				ret_cnt_q <= 16'h0000;
			end else if (ret_run_q && tick) begin
				if (ret_cnt_q >= other_dly_q) ret_run_q <= 1'b0;
				else ret_cnt_q <= ret_cnt_q + 16'h0001;
			end
		end
	end

	// Transfer blocking and initiation for incomers
	logic xfer_block, xfer_init;
	assign xfer_block = blk | !own_conn | !tie_conn | !oth_cl | oth_uv
		| oc_any // [RULE15]
		| (fast_uv & (oc_any | rec_run_q)) | oc_prev_q | rec_run_q // [RULE4]
		| ret_run_q | dbl_seen_q // [RULE5]
		| dbl_loss; // [RULE7]
	assign xfer_init = is_inc && !xfer_block
		&& (timed_uv | lockout | src_trip); // [RULE17]

	// Incomer sequencer
	xfer_state_t st_q;
	logic inc_trip_q;
	logic close_req_q;

	// Trip held until own breaker seen open or role changes
	always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			st_q <= XFER_IDLE;
			inc_trip_q <= 1'b0;
			close_req_q <= 1'b0;
		end else begin
			case (st_q)
				XFER_IDLE: begin
					if (xfer_init) begin
						st_q <= XFER_TRIP;
						inc_trip_q <= 1'b1; // [RULE22]
						close_req_q <= 1'b1;
					end
				end
				XFER_TRIP: begin
					if (!own_cl || !is_inc) begin
						st_q <= XFER_DONE;
						inc_trip_q <= 1'b0;
					end
				end
				XFER_DONE: begin
					// Close request stays until source voltage returns or role changes
					if (!timed_uv || !is_inc) begin
						st_q <= XFER_IDLE;
						close_req_q <= 1'b0;
					end
				end
				default: begin
					st_q <= XFER_IDLE;
					inc_trip_q <= 1'b0;
					close_req_q <= 1'b0;
				end
			endcase
		end
	end

	// Double loss timed undervoltage trip, unless inhibited
	logic dbl_trip;
	assign dbl_trip = is_inc && dbl_loss && !dbl_inh_q; // [RULE6]

	// Tie close request latch
	logic tie_req_q;
	always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
		if (!i_reset_n) tie_req_q <= 1'b0;
		else if (!is_tie || tie_cl || blk) tie_req_q <= 1'b0; // [RULE23]
		else if (close_in) tie_req_q <= 1'b1;
	end

	// Parallel-trip start conditions
	logic par_start;
	assign par_start = !blk && tie_conn && tie_cl && sel_trip &&
		((is_inc && own_conn && oth_cl) || // [RULE9]
		(is_tie && own_cl && oth_cl)); // [RULE10]

	// Parallel-trip delay
	logic [15:0] par_cnt_q;
	logic par_exp_q;
	always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			par_cnt_q <= 16'h0000;
			par_exp_q <= 1'b0;
		end else if (!par_start) begin
			par_cnt_q <= 16'h0000; // [RULE24]
			par_exp_q <= 1'b0;
		end else if (tick && !par_exp_q) begin
			if (par_cnt_q >= par_dly_q) par_exp_q <= 1'b1; // [RULE8]
			else par_cnt_q <= par_cnt_q + 16'h0001;
		end
	end

	// Transfer-ready flag
	logic ready;
	assign ready = !blk && (
		(is_inc && !tie_cl && own_conn && own_cl && oth_cl && !lockout && !src_trip
			&& !fast_uv && !oth_uv) || // [RULE11]
		(is_tie && tie_conn && !tie_cl && own_cl && oth_cl)); // [RULE12]

	// Registered outputs; auxiliaries 4-7 carry only transfer signals
	always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_aux3_ready <= 1'b0;
			o_aux4_uv_other <= 1'b0;
			o_aux5_close_req <= 1'b0;
			o_aux6_tie_close <= 1'b0;
			o_aux7_sync_block <= 1'b0;
			o_trip <= 1'b0;
		end else begin
			o_aux3_ready <= rdy_en_q && ready; // [RULE13]
			o_aux4_uv_other <= is_inc && fast_uv; // [RULE16] [RULE14]
			o_aux5_close_req <= is_inc && close_req_q; // [RULE14]
			o_aux6_tie_close <= is_tie && tie_req_q; // [RULE14]
			o_aux7_sync_block <= is_tie && tie_req_q; // [RULE19]
			o_trip <= inc_trip_q || dbl_trip || par_exp_q; // [RULE8]
		end
	end

	// Read port: data one cycle after strobe, zero otherwise
	always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
		if (!i_reset_n) o_rdata <= 16'h0000;
		else if (!i_rd) o_rdata <= 16'h0000;
		else begin
			case (i_addr)
				REG_CTRL: o_rdata <= {11'h000, rdy_en_q, dbl_inh_q, scheme_q, role_q};
				REG_LOCAL_DLY: o_rdata <= local_dly_q;
				REG_OTHER_DLY: o_rdata <= other_dly_q;
				REG_PAR_DLY: o_rdata <= par_dly_q;
				REG_STATUS: o_rdata <= {10'h000, ret_run_q, rec_run_q, par_exp_q,
					tie_req_q, inc_trip_q, ready};
				default: o_rdata <= 16'h0000;
			endcase
		end
	end

	// Checks
	a_ready_output: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
		o_aux3_ready |-> $past(rdy_en_q)) // [RULE13]
		else $error("ready output without enable");
	a_tie_close_dbl: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
		(dbl_loss && !close_req_q) |=> !close_req_q) // [RULE7]
		else $error("transfer during double loss");
	a_trip_hold: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
		(st_q == XFER_TRIP && own_cl && is_inc) |=> inc_trip_q) // [RULE22]
		else $error("trip dropped before open");
	a_tie_latch: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
		(tie_req_q && !tie_cl && !blk && is_tie) |=> tie_req_q) // [RULE23]
		else $error("close request lost");
	a_par_restart: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
		!par_start |=> (par_cnt_q == 16'h0000 && !par_exp_q)) // [RULE24]
		else $error("parallel delay not restarted");
	a_par_start: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
		par_exp_q |-> $past(par_start)) // [RULE9]
		else $error("parallel trip without start");
	a_disabled_idle: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
		(role_q == ROLE_DISABLED) |-> (!ready && !xfer_init)) // [RULE1]
		else $error("logic active when disabled");
	a_oc_block: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
		oc_any |-> !xfer_init) // [RULE15]
		else $error("transfer during overcurrent");
	a_dbl_trip: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
		(dbl_trip) |=> o_trip) // [RULE6]
		else $error("double loss trip missing");

	c_transfer: cover property (@(posedge i_ref_clk) disable iff (!i_reset_n) xfer_init);
	c_par_trip: cover property (@(posedge i_ref_clk) disable iff (!i_reset_n) par_exp_q);
	c_tie_req: cover property (@(posedge i_ref_clk) disable iff (!i_reset_n) tie_req_q);
	c_ready: cover property (@(posedge i_ref_clk) disable iff (!i_reset_n) o_aux3_ready);

endmodule

`default_nettype wire

// ### breaker_contacts_model.sv
// Behavioural model of the breaker auxiliary contacts around one relay.
// Assumes commands are levels on the relay clock; contacts move after travel time on trip and tie commands, at once on operator actions.
`timescale 1ns/1ps
`default_nettype none
module breaker_contacts_model #(
	parameter int OP_CYCLES = 8
) (
	input wire logic i_ref_clk,
	input wire logic i_reset_n,
	input wire logic i_trip,
	input wire logic i_tie_cmd,
	input wire logic i_close_own,
	input wire logic i_open_tie,
	input wire logic i_close_tie,
	output logic o_own_closed,
	output logic o_tie_closed
);
	int trip_cnt; // Own mechanism travel
	int tie_cnt; // Tie mechanism travel

	// Own breaker opens only after a trip held for the full travel time
	always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_own_closed <= 1'b1;
			trip_cnt <= 0;
		end else if (i_close_own) begin // Operator close on live line, dead bus
			o_own_closed <= 1'b1;
			trip_cnt <= 0;
		end else if (i_trip) begin
			trip_cnt <= trip_cnt + 1;
			if (trip_cnt == OP_CYCLES) o_own_closed <= 1'b0;
		end else begin
			// A dropped command never completes the stroke
			trip_cnt <= 0;
		end
	end

	// Tie closes on a held close request or on an operator close
	always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_tie_closed <= 1'b0;
			tie_cnt <= 0;
		end else if (i_open_tie) begin
			o_tie_closed <= 1'b0;
			tie_cnt <= 0;
		end else if (i_close_tie) begin
			o_tie_closed <= 1'b1;
		end else if (i_tie_cmd) begin // Held close request from the relay
			tie_cnt <= tie_cnt + 1;
			if (tie_cnt == OP_CYCLES) o_tie_closed <= 1'b1;
		end else begin
			tie_cnt <= 0;
		end
	end
endmodule
`default_nettype wire

// ### bus_transfer_interlock_tb.sv
// Self-checking bench for the bus transfer interlock, one relay at a time.
// Assumes the contact model above; delays are programmed to one tick.
`timescale 1ns/1ps
`default_nettype none
module bus_transfer_interlock_tb;
	import bus_transfer_pkg::*;
	logic i_ref_clk = 1'b0; // 20 MHz
	logic i_reset_n = 1'b0;
	logic [3:0] i_addr = 4'h0;
	logic [15:0] i_wdata = 16'h0000;
	logic i_wr = 1'b0, i_rd = 1'b0;
	logic i_own_connected = 1'b1, i_other_closed = 1'b1, i_tie_connected = 1'b1;
	logic i_parallel_trip_selection_input = 1'b0, i_block_transfer = 1'b0;
	logic i_lockout = 1'b0, i_source_trip = 1'b0, i_other_uv = 1'b0, i_close_req = 1'b0;
	logic i_inst_phase_overcurrent = 1'b0, i_inst_neutral_overcurrent = 1'b0;
	logic i_fast_uv = 1'b0, i_timed_uv = 1'b0, i_other_source_lost = 1'b0;
	logic [2:0] op_q = 3'h0; // Operator actions, one bit each
	localparam int OP_CLOSE_OWN = 0;
	localparam int OP_OPEN_TIE = 1;
	localparam int OP_CLOSE_TIE = 2;
	logic [15:0] o_rdata;
	logic o_aux3_ready, o_aux4_uv_other, o_aux5_close_req, o_aux6_tie_close;
	logic o_aux7_sync_block, o_trip, i_own_closed, i_tie_closed;
	int err_total = 0;
	int n_tests = 0;
	int cyc_cnt = 0;

	bus_transfer_interlock uut (.i_ref_clk, .i_reset_n, .i_addr, .i_wdata, .i_wr, .i_rd,
		.o_rdata, .i_own_connected, .i_own_closed, .i_other_closed, .i_tie_connected,
		.i_tie_closed, .i_parallel_trip_selection_input, .i_block_transfer, .i_lockout,
		.i_source_trip, .i_other_uv, .i_close_req, .i_inst_phase_overcurrent,
		.i_inst_neutral_overcurrent, .i_fast_uv, .i_timed_uv, .i_other_source_lost,
		.o_aux3_ready, .o_aux4_uv_other, .o_aux5_close_req, .o_aux6_tie_close,
		.o_aux7_sync_block, .o_trip);

	breaker_contacts_model peer (.i_ref_clk, .i_reset_n, .i_trip(o_trip),
		.i_tie_cmd(o_aux6_tie_close), .i_close_own(op_q[OP_CLOSE_OWN]),
		.i_open_tie(op_q[OP_OPEN_TIE]), .i_close_tie(op_q[OP_CLOSE_TIE]),
		.o_own_closed(i_own_closed), .o_tie_closed(i_tie_closed));

	// Free-running clock
	always #25 i_ref_clk = ~i_ref_clk;

	// Hang guard: longest wait is one one-tick delay, up to two ticks
	always @(posedge i_ref_clk) begin
		cyc_cnt = cyc_cnt + 1;
		if (cyc_cnt == 90000) begin
			err_total = err_total + 1;
			summarize();
		end
	end

	task automatic summarize();
		$display("mismatches %0d, checks %0d", err_total, n_tests);
		if (err_total == 0 && n_tests > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge i_ref_clk);
	endtask

	// Compare with four-state equality so an unknown matches only the same unknown in the expected value
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_tests = n_tests + 1;
		if (got !== exp) begin
			err_total = err_total + 1;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge i_ref_clk);
		i_wr <= 1'b1;
		i_addr <= a;
		i_wdata <= d;
		@(posedge i_ref_clk);
		i_wr <= 1'b0;
	endtask

	// Read data stand only in the cycle after the strobe
	task automatic rd(input logic [3:0] a, output logic [15:0] d);
		@(posedge i_ref_clk);
		i_rd <= 1'b1;
		i_addr <= a;
		@(posedge i_ref_clk);
		i_rd <= 1'b0;
		#1 d = o_rdata;
	endtask

	task automatic setc(input role_t r, input logic inh, input logic en);
		logic [15:0] v;
		v = 16'(r) | (16'(inh) << CTRL_DBL_INH) | (16'(en) << CTRL_RDY_EN);
		wr(REG_CTRL, v); // Scheme bit stays at scheme one, as on the peers
	endtask

	// One-cycle operator action; a quiet cycle after it keeps pulses apart
	task automatic pulse(input int k);
		op_q <= 3'(1 << k);
		cyc(1);
		op_q <= 3'h0;
		cyc(1);
	endtask

	// Bounded wait for a trip; returns whether it came
	task automatic wait_trip(input int n, output logic seen);
		int i;
		seen = 1'b0;
		for (i = 0; i < n && seen !== 1'b1; i++) begin
			@(posedge i_ref_clk);
			#1 seen = o_trip;
		end
	endtask

	task automatic t_regs();
		logic [15:0] d;
		rd(REG_CTRL, d);
		chk(d, 16'h0000);
		rd(REG_PAR_DLY, d);
		chk(d, DLY_RST);
		rd(4'hF, d);
		chk(d, 16'h0000);
		wr(REG_CTRL, 16'h0001 << CTRL_SCHEME); // Scheme two, role disabled
		rd(REG_CTRL, d);
		chk(d, 16'h0001 << CTRL_SCHEME);
		wr(REG_LOCAL_DLY, 16'h0001);
		wr(REG_OTHER_DLY, 16'h0001);
		wr(REG_PAR_DLY, 16'h0001);
		rd(REG_PAR_DLY, d);
		chk(d, 16'h0001);
	endtask

	task automatic t_ready();
		setc(ROLE_INCOMER1, 1'b0, 1'b1);
		cyc(6);
		chk(o_aux3_ready, 1'b1);
		i_block_transfer <= 1'b1;
		cyc(6);
		chk(o_aux3_ready, 1'b0);
		i_block_transfer <= 1'b0;
		i_lockout <= 1'b1;
		cyc(6);
		chk(o_aux3_ready, 1'b0);
		chk(o_trip, 1'b1);
		i_lockout <= 1'b0;
		cyc(20);
		chk(o_trip, 1'b0);
		pulse(OP_CLOSE_OWN); // Reclose after the lockout transfer
		setc(ROLE_INCOMER1, 1'b0, 1'b0);
		cyc(6);
		chk(o_aux3_ready, 1'b0);
		setc(ROLE_DISABLED, 1'b0, 1'b1);
		cyc(6);
		chk(o_aux3_ready, 1'b0);
	endtask

	task automatic t_tie();
		logic [15:0] d;
		setc(ROLE_BUS_TIE, 1'b0, 1'b1);
		cyc(6);
		chk(o_aux3_ready, 1'b1);
		i_close_req <= 1'b1;
		cyc(2);
		i_close_req <= 1'b0;
		cyc(3);
		chk(o_aux6_tie_close, 1'b1);
		chk(o_aux7_sync_block, 1'b1);
		rd(REG_STATUS, d);
		chk(d, 16'h0005);
		cyc(20);
		chk(o_aux6_tie_close, 1'b0);
		chk(o_aux3_ready, 1'b0);
		pulse(OP_OPEN_TIE);
		i_close_req <= 1'b1;
		cyc(1);
		i_close_req <= 1'b0;
		cyc(3);
		i_block_transfer <= 1'b1;
		cyc(6);
		chk(o_aux6_tie_close, 1'b0);
		i_block_transfer <= 1'b0;
	endtask

	task automatic t_transfer();
		setc(ROLE_INCOMER1, 1'b0, 1'b0);
		i_timed_uv <= 1'b1; // Fast element stays quiet
		cyc(5);
		chk(o_trip, 1'b1);
		chk(o_aux5_close_req, 1'b1);
		cyc(20);
		chk(o_trip, 1'b0);
		i_timed_uv <= 1'b0;
		cyc(5);
		pulse(OP_CLOSE_OWN);
		i_fast_uv <= 1'b1;
		cyc(5);
		chk(o_aux4_uv_other, 1'b1);
		i_fast_uv <= 1'b0;
		i_inst_phase_overcurrent <= 1'b1;
		i_timed_uv <= 1'b1;
		cyc(8);
		chk(o_trip, 1'b0);
		i_inst_phase_overcurrent <= 1'b0;
		i_inst_neutral_overcurrent <= 1'b1;
		cyc(8);
		chk(o_trip, 1'b0);
		i_inst_neutral_overcurrent <= 1'b0;
		cyc(8);
		chk(o_trip, 1'b0);
		i_timed_uv <= 1'b0;
	endtask

	task automatic t_parallel();
		logic seen;
		pulse(OP_CLOSE_TIE);
		i_parallel_trip_selection_input <= 1'b1;
		cyc(100);
		chk(o_trip, 1'b0);
		wait_trip(45000, seen);
		chk(seen, 1'b1);
		cyc(1); // Back onto the rising edge before driving
		i_parallel_trip_selection_input <= 1'b0;
		cyc(20);
		pulse(OP_OPEN_TIE);
		pulse(OP_CLOSE_OWN);
	endtask

	task automatic t_double();
		logic [15:0] d;
		setc(ROLE_INCOMER1, 1'b1, 1'b0);
		i_other_source_lost <= 1'b1;
		i_timed_uv <= 1'b1;
		cyc(8);
		chk(o_trip, 1'b0);
		chk(o_aux5_close_req, 1'b0);
		setc(ROLE_INCOMER1, 1'b0, 1'b0);
		cyc(4);
		chk(o_trip, 1'b1);
		chk(o_aux5_close_req, 1'b0);
		i_other_source_lost <= 1'b0; // Other source back first, own still low
		cyc(6);
		chk(o_trip, 1'b0);
		chk(o_aux5_close_req, 1'b0);
		rd(REG_STATUS, d);
		chk(d & 16'h0020, 16'h0020);
	endtask

	// Main sequence: reset, then scenarios in order
	initial begin
		repeat (8) @(posedge i_ref_clk);
		i_reset_n <= 1'b1;
		t_regs();
		t_ready();
		t_tie();
		t_transfer();
		t_parallel();
		t_double();
		summarize();
	end
endmodule
`default_nettype wire
